/* logic/bst_tap.sv */
`timescale 1ns/1ps
module bst_tap #(
    parameter int          BSR_LEN = bst_pkg::BSR_LEN_DEF,
    parameter int          OE_BIT  = bst_pkg::OE_BIT_DEF,
    parameter logic [31:0] ID_CODE = bst_pkg::ID_CODE_DEF
) (
    input  wire logic               SYS_CLK,
    input  wire logic               RSTN,
    input  wire logic               TCK,
    input  wire logic               TMS,
    input  wire logic               TDI,
    output logic                    TDO,
    output logic                    TDO_OE_N,
    input  wire logic [BSR_LEN-1:0] BSR_PIN,
    output logic      [BSR_LEN-1:0] BSR_DRIVE,
    output logic                    EXTEST_MODE,
    output logic                    OUT_BUS_HIZ
);
    logic [2:0]                 pin_s;
    logic                       tck_s;
    logic                       tms_s;
    logic                       tdi_s;
    logic                       tck_d;
    logic                       next_tck_d;
    logic                       tck_rise;
    logic                       tck_fall;
    bst_pkg::bst_state_t        state;
    bst_pkg::bst_state_t        next_state;
    logic [bst_pkg::IR_W-1:0]   ir;
    logic [bst_pkg::IR_W-1:0]   next_ir;
    logic [bst_pkg::IR_W-1:0]   ir_shift;
    logic [bst_pkg::IR_W-1:0]   next_ir_shift;
    logic                       byp;
    logic                       next_byp;
    logic [bst_pkg::ID_W-1:0]   id_shift;
    logic [bst_pkg::ID_W-1:0]   next_id_shift;
    logic                       next_tdo;
    logic                       next_tdo_oe_n;
    logic [BSR_LEN-1:0]         next_drive;
    logic                       next_extest;
    logic                       next_hiz;
    logic                       sel_id;
    logic                       sel_bsr;
    logic                       sel_byp;
    logic                       bsr_cap;
    logic                       bsr_shf;
    logic                       bsr_upd;
    logic                       tlr;
    logic [BSR_LEN:0]           chain;
    logic [BSR_LEN-1:0]         upd_q;

    // idle mode select and data in read high (test clock low), so an undriven port walks into reset
    bst_sync #(
        .WIDTH   (3),
        .RST_VAL (bst_pkg::SYNC_RST)
    ) u_sync (
        .clk  (SYS_CLK),
        .rstn (RSTN),
        .d    ({TDI, TMS, TCK}),
        .q    (pin_s)
    );

    assign tck_s = pin_s[0];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[2];

    // edges of the test clock, found on the system clock
    always_comb begin
        next_tck_d = tck_s;
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= next_tck_d;
        end
    end

    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;
    assign tlr      = (state == bst_pkg::ST_TLR);

    // controller
    always_comb begin
        next_state = state;
        if (tck_rise) begin
            unique case (state)
                bst_pkg::ST_TLR:    next_state = tms_s ? bst_pkg::ST_TLR    : bst_pkg::ST_IDLE;
                bst_pkg::ST_IDLE:   next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_DR: next_state = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
                bst_pkg::ST_CAP_DR: next_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
                bst_pkg::ST_SHF_DR: next_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SHF_DR;
                bst_pkg::ST_EX1_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_PAU_DR: next_state = tms_s ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_EX2_DR: next_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHF_DR;
                bst_pkg::ST_UPD_DR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_IR: next_state = tms_s ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
                bst_pkg::ST_CAP_IR: next_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
                bst_pkg::ST_SHF_IR: next_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SHF_IR;
                bst_pkg::ST_EX1_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_PAU_IR: next_state = tms_s ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_EX2_IR: next_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHF_IR;
                bst_pkg::ST_UPD_IR: next_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            endcase
        end
    end

    // power-up lands in test-logic-reset; memory pins untouched there
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= bst_pkg::ST_TLR;
        end else begin
            state <= next_state;
        end
    end

    // instruction register
    always_comb begin
        next_ir_shift = ir_shift;
        next_ir       = ir;
        if (tck_rise && state == bst_pkg::ST_CAP_IR) begin
            next_ir_shift = bst_pkg::IR_CAPTURE;
        end else if (tck_rise && state == bst_pkg::ST_SHF_IR) begin
            next_ir_shift = {tdi_s, ir_shift[bst_pkg::IR_W-1:1]};
        end
        if (tlr) begin
            next_ir = bst_pkg::INS_IDCODE;
        end else if (tck_fall && state == bst_pkg::ST_UPD_IR) begin
            next_ir = ir_shift;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ir_shift <= bst_pkg::IR_CAPTURE;
            ir       <= bst_pkg::INS_IDCODE;
        end else begin
            ir_shift <= next_ir_shift;
            ir       <= next_ir;
        end
    end

    // data register select; reserved codes fall back to bypass
    assign sel_id  = (ir == bst_pkg::INS_IDCODE);
    assign sel_bsr = (ir == bst_pkg::INS_EXTEST) || (ir == bst_pkg::INS_SAMPLE)
                     || (ir == bst_pkg::INS_SAMPLE_Z);
    assign sel_byp = !sel_id && !sel_bsr;

    // bypass and identification registers
    always_comb begin
        next_byp      = byp;
        next_id_shift = id_shift;
        if (tck_rise && state == bst_pkg::ST_CAP_DR) begin
            if (sel_byp) begin
                next_byp = 1'b0;
            end
            if (sel_id) begin
                next_id_shift = ID_CODE;
            end
        end else if (tck_rise && state == bst_pkg::ST_SHF_DR) begin
            if (sel_byp) begin
                next_byp = tdi_s;
            end
            if (sel_id) begin
                next_id_shift = {tdi_s, id_shift[bst_pkg::ID_W-1:1]};
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            byp      <= 1'b0;
            id_shift <= '0;
        end else begin
            byp      <= next_byp;
            id_shift <= next_id_shift;
        end
    end

    // boundary chain: data in enters the top cell, out leaves cell 0
    assign bsr_cap = tck_rise && state == bst_pkg::ST_CAP_DR && sel_bsr;
    assign bsr_shf = tck_rise && state == bst_pkg::ST_SHF_DR && sel_bsr;
    assign bsr_upd = tck_fall && state == bst_pkg::ST_UPD_DR
                     && (ir == bst_pkg::INS_EXTEST || ir == bst_pkg::INS_SAMPLE);
    assign chain[BSR_LEN] = tdi_s;

    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi++) begin : g_cell
            bst_cell #(
                .UPD_RST ((gi == OE_BIT) ? 1'b1 : 1'b0)
            ) u_cell (
                .clk     (SYS_CLK),
                .rstn    (RSTN),
                .tlr     (tlr),
                .capture (bsr_cap),
                .shift   (bsr_shf),
                .update  (bsr_upd),
                .pin     (BSR_PIN[gi]),
                .sin     (chain[gi+1]),
                .sout    (chain[gi]),
                .upd_q   (upd_q[gi])
            );
        end
    endgenerate

    // serial output, moved only on the falling test clock edge
    always_comb begin
        next_tdo      = TDO;
        next_tdo_oe_n = TDO_OE_N;
        if (tck_fall) begin
            next_tdo_oe_n = !(state == bst_pkg::ST_SHF_IR || state == bst_pkg::ST_SHF_DR);
            if (state == bst_pkg::ST_SHF_IR) begin
                next_tdo = ir_shift[0];
            end else if (sel_id) begin
                next_tdo = id_shift[0];
            end else if (sel_bsr) begin
                next_tdo = chain[0];
            end else begin
                next_tdo = byp;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            TDO      <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else begin
            TDO      <= next_tdo;
            TDO_OE_N <= next_tdo_oe_n;
        end
    end

    // pin-side controls; enable cell only bites under external test
    always_comb begin
        next_drive  = upd_q;
        next_extest = (ir == bst_pkg::INS_EXTEST);
        next_hiz    = (ir == bst_pkg::INS_SAMPLE_Z)
                      || ((ir == bst_pkg::INS_EXTEST) && !upd_q[OE_BIT]);
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            BSR_DRIVE   <= '0;
            EXTEST_MODE <= 1'b0;
            OUT_BUS_HIZ <= 1'b0;
        end else begin
            BSR_DRIVE   <= next_drive;
            EXTEST_MODE <= next_extest;
            OUT_BUS_HIZ <= next_hiz;
        end
    end

    // helper: consecutive rising edges with mode select high
    logic [2:0]                 tms_cnt;
    logic [2:0]                 next_tms_cnt;

    // saturates so the check keeps holding while mode select stays high
    always_comb begin
        next_tms_cnt = tms_cnt;
        if (tck_rise) begin
            if (!tms_s) begin
                next_tms_cnt = 3'h0;
            end else if (tms_cnt != 3'(bst_pkg::RST_TMS_HIGH)) begin
                next_tms_cnt = tms_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tms_cnt <= 3'h0;
        end else begin
            tms_cnt <= next_tms_cnt;
        end
    end

    a_five_tms_reset: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (tms_cnt == 3'(bst_pkg::RST_TMS_HIGH)) |-> (state == bst_pkg::ST_TLR))
        else $error("five high mode-select edges did not reset the controller");

    a_ir_idcode_tlr: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (state == bst_pkg::ST_TLR) |=> (ir == bst_pkg::INS_IDCODE))
        else $error("instruction not identify after test-logic-reset");

    a_ir_capture_01: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (tck_rise && state == bst_pkg::ST_CAP_IR) |=> (ir_shift[1:0] == 2'h1))
        else $error("instruction capture did not load 01");

    a_bypass_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (tck_rise && state == bst_pkg::ST_CAP_DR && sel_byp) |=> (byp == 1'b0))
        else $error("bypass flop not cleared at capture");

    a_id_capture: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (tck_rise && state == bst_pkg::ST_CAP_DR && sel_id) |=> (id_shift == ID_CODE))
        else $error("identification code not captured");

    a_tdo_on_fall: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ($changed(TDO) || $changed(TDO_OE_N)) |-> $past(tck_fall))
        else $error("serial output moved off the falling edge");

    a_tdo_hiz_idle: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (tck_fall && state != bst_pkg::ST_SHF_IR && state != bst_pkg::ST_SHF_DR)
        |=> TDO_OE_N)
        else $error("serial output driven outside shift states");

    a_ir_only_update: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        $changed(ir) |-> ($past(state) == bst_pkg::ST_UPD_IR || $past(state) == bst_pkg::ST_TLR))
        else $error("instruction changed outside update");

    a_samplez_hiz: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (ir == bst_pkg::INS_SAMPLE_Z) |=> OUT_BUS_HIZ)
        else $error("output bus not floated under sample-hiz");

    a_oe_cell_preset: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        (state == bst_pkg::ST_TLR) |=> ##1 BSR_DRIVE[OE_BIT])
        else $error("output enable cell not preset in test-logic-reset");

endmodule

/* logic/bst_pkg.sv */
// Operation
// - undriven mode select reads as one
// - all test inputs sampled on rising clock
// - data out changes on falling edge, shifting only
// - data in to MSB, out from LSB
// - one register selected, chosen by instruction
// - five mode-select-high clocks reset the port
// - power-up reset leaves data out undriven
// - three-bit instruction, identify after reset
// - instruction capture loads 01 into LSBs
// - single bypass flop captures zero
// - boundary chain captures pins, then shifts
// - identify instruction captures hardwired 32-bit code
// - identify code shifts out in data shift
// - new instruction takes effect at update
// - sample-hiz selects chain, floats output bus
// - sample/preload snapshots all pins at capture
// - preload places pattern on latched cell outputs
// - captured values out while preload shifts in
// - bypass instruction puts bypass flop in path
// - external test drives preloaded values out
// - enable cell gates output drivers in external test
// - enable cell preset to one at reset
package bst_pkg;

    localparam int          IR_W         = 3;
    localparam int          ID_W         = 32;
    localparam int          BSR_LEN_DEF  = 90;
    localparam int          OE_BIT_DEF   = 89;
    localparam int          RST_TMS_HIGH = 5;

    localparam logic [2:0]  INS_EXTEST   = 3'h0;
    localparam logic [2:0]  INS_IDCODE   = 3'h1;
    localparam logic [2:0]  INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0]  INS_SAMPLE   = 3'h4;
    localparam logic [2:0]  INS_BYPASS   = 3'h7;
    localparam logic [2:0]  IR_CAPTURE   = 3'h1;

    // arbitrary value, not a real maker code
    localparam logic [31:0] ID_CODE_DEF  = 32'h0a5a_5001;

    // reset values of the synchroniser: {data in, mode select, test clock}
    localparam logic [2:0]  SYNC_RST     = 3'h6;

    typedef enum logic [3:0] {
        ST_TLR     = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h2,
        ST_CAP_DR  = 4'h3,
        ST_SHF_DR  = 4'h4,
        ST_EX1_DR  = 4'h5,
        ST_PAU_DR  = 4'h6,
        ST_EX2_DR  = 4'h7,
        ST_UPD_DR  = 4'h8,
        ST_SEL_IR  = 4'h9,
        ST_CAP_IR  = 4'ha,
        ST_SHF_IR  = 4'hb,
        ST_EX1_IR  = 4'hc,
        ST_PAU_IR  = 4'hd,
        ST_EX2_IR  = 4'he,
        ST_UPD_IR  = 4'hf
    } bst_state_t;

endpackage

/* logic/bst_sync.sv */
`timescale 1ns/1ps
module bst_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    // reset value stands for an idle, pulled-up pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

/* logic/bst_cell.sv */
`timescale 1ns/1ps
module bst_cell #(
    parameter logic UPD_RST = 1'b0
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic tlr,
    input  wire logic capture,
    input  wire logic shift,
    input  wire logic update,
    input  wire logic pin,
    input  wire logic sin,
    output logic      sout,
    output logic      upd_q
);
    logic next_sout;
    logic next_upd_q;

    always_comb begin
        next_sout  = sout;
        next_upd_q = upd_q;
        if (capture) begin
            next_sout = pin;
        end else if (shift) begin
            next_sout = sin;
        end
        if (tlr) begin
            next_upd_q = UPD_RST;
        end else if (update) begin
            next_upd_q = sout;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sout  <= 1'b0;
            upd_q <= UPD_RST;
        end else begin
            sout  <= next_sout;
            upd_q <= next_upd_q;
        end
    end
endmodule

/* testbench/bst_jtag_host.sv */
`timescale 1ns/1ps
module bst_jtag_host (
    input  wire logic sys_clk,
    input  wire logic tdo,
    input  wire logic tdo_oe_n,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    int unsigned n_unstable;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        n_unstable = 0;
    end

    // one test clock of 20 system clocks; tdo read just before the rise
    task automatic tick(input logic m, input logic d, output logic q, output logic qz);
        @(posedge sys_clk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge sys_clk);
        q = tdo;
        qz = tdo_oe_n;
        tck <= 1'b1;
        repeat (10) @(posedge sys_clk);
        // tdo must not move while the clock is high
        if (tdo !== q || tdo_oe_n !== qz) n_unstable++;
        tck <= 1'b0;
        repeat (5) @(posedge sys_clk);
        // released lines float to the pull-up level
        tms <= 1'b1;
        tdi <= 1'b1;
    endtask

    task automatic tlr();
        logic q;
        logic qz;
        repeat (5) tick(1'b1, 1'b1, q, qz);
    endtask

    // starts and ends in run-test-idle
    task automatic scan(input logic ir, input logic [63:0] din, input int n,
                        output logic [63:0] dout, output logic oe_ok);
        logic q;
        logic qz;
        dout = '0;
        oe_ok = 1'b1;
        tick(1'b1, 1'b1, q, qz);
        if (ir) tick(1'b1, 1'b1, q, qz);
        tick(1'b0, 1'b1, q, qz);
        tick(1'b0, 1'b1, q, qz);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q, qz);
            dout[i] = q;
            if (qz !== 1'b0) oe_ok = 1'b0;
        end
        tick(1'b1, 1'b1, q, qz);
        tick(1'b0, 1'b1, q, qz);
    endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int          BL = 16;
    localparam int          OB = 12;
    // arbitrary value, names no maker
    localparam logic [31:0] ID = 32'h0c3c_7001;

    logic          sys_clk;
    logic          rstn;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe_n;
    logic [BL-1:0] pins;
    logic [BL-1:0] drive;
    logic          extest;
    logic          hiz;
    logic [63:0]   got;
    logic          ok;
    logic          q;
    logic          qz;
    int            n_errors;
    int            total_checks;

    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    bst_tap #(.BSR_LEN(BL), .OE_BIT(OB), .ID_CODE(ID)) DUT (
        .SYS_CLK(sys_clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi),
        .TDO(tdo), .TDO_OE_N(tdo_oe_n), .BSR_PIN(pins), .BSR_DRIVE(drive),
        .EXTEST_MODE(extest), .OUT_BUS_HIZ(hiz)
    );

    bst_jtag_host host (
        .sys_clk(sys_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .tck(tck), .tms(tms), .tdi(tdi)
    );

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic load_ir(input logic [2:0] code);
        host.scan(1'b1, {61'h0, code}, 3, got, ok);
        check("ir_capture", got, 64'h1);
        check("ir_oe", 64'(ok), 64'h1);
    endtask

    task automatic t_power_up();
        check("oe_reset", 64'(tdo_oe_n), 64'h1);
        check("en_cell", 64'(drive[OB]), 64'h1);
        check("ext_reset", 64'(extest), 64'h0);
        host.tick(1'b0, 1'b1, q, qz);
        host.scan(1'b0, 64'ha5, 40, got, ok);
        check("id_code", 64'(got[31:0]), 64'(ID));
        check("id_msb_in", 64'(got[39:32]), 64'ha5);
        check("dr_oe", 64'(ok), 64'h1);
        check("oe_idle", 64'(tdo_oe_n), 64'h1);
    endtask

    task automatic t_bypass();
        load_ir(3'h7);
        host.scan(1'b0, 64'hc3, 9, got, ok);
        check("byp_first", 64'(got[0]), 64'h0);
        check("byp_delay", 64'(got[8:1]), 64'hc3);
        check("byp_hiz", 64'(hiz), 64'h0);
    endtask

    task automatic t_preload();
        pins <= 16'h5a3c;
        load_ir(3'h4);
        host.scan(1'b0, 64'h2b6d, BL, got, ok);
        check("smp_out", got, 64'h5a3c);
        check("pre_drive", 64'(drive), 64'h2b6d);
        check("pre_ext", 64'(extest), 64'h0);
    endtask

    task automatic t_extest();
        load_ir(3'h0);
        check("ext_on", 64'(extest), 64'h1);
        check("ext_drive", 64'(drive), 64'h2b6d);
        check("ext_float", 64'(hiz), 64'h1);
        host.scan(1'b0, 64'h9001, BL, got, ok);
        check("ext_chain", got, 64'h5a3c);
        check("ext_drive2", 64'(drive), 64'h9001);
        check("ext_enable", 64'(hiz), 64'h0);
    endtask

    task automatic t_sample_z();
        load_ir(3'h2);
        check("sz_float", 64'(hiz), 64'h1);
        check("sz_ext", 64'(extest), 64'h0);
        pins <= 16'h1234;
        host.scan(1'b0, 64'h0, BL, got, ok);
        check("sz_chain", got, 64'h1234);
        check("sz_hold", 64'(hiz), 64'h1);
    endtask

    task automatic t_tms_reset();
        host.tlr();
        check("tlr_oe", 64'(tdo_oe_n), 64'h1);
        check("tlr_hiz", 64'(hiz), 64'h0);
        check("tlr_en", 64'(drive[OB]), 64'h1);
        host.tick(1'b0, 1'b1, q, qz);
        host.scan(1'b0, 64'h0, 32, got, ok);
        check("tlr_id", got, 64'(ID));
    endtask

    task automatic t_second_reset();
        load_ir(3'h0);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("rst_oe", 64'(tdo_oe_n), 64'h1);
        check("rst_ext", 64'(extest), 64'h0);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("rst_en", 64'(drive[OB]), 64'h1);
    endtask

    initial begin
        n_errors = 0;
        total_checks = 0;
        rstn = 1'b0;
        pins = '0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_power_up();
        t_bypass();
        t_preload();
        t_extest();
        t_sample_z();
        t_tms_reset();
        t_second_reset();
        check("tdo_stable", 64'(host.n_unstable), 64'h0);
        conclude();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end
endmodule
